// file: hdl/acfg_pkg.sv
// constants and carrier types for the two adc configuration registers
// assumes a 32-bit apb master on the core_clk domain
package acfg_pkg;
	// register word addresses (byte offsets)
	localparam logic [7:0] OFF_RATE = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_PIN = 8'h10;
	localparam logic [7:0] OFF_EVT = 8'h20;
	localparam logic [7:0] OFF_EVT_EN = 8'h24;
	localparam logic [7:0] OFF_EVT_CLR = 8'h28;
	localparam logic [7:0] OFF_RESULT = 8'h2C;
	// reset values
	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [7:0] RST_STAT = 8'h00;
	// field positions
	localparam int POS_RATE = 5;
	localparam int POS_FAST = 4;
	localparam int POS_CONT = 3;
	localparam int POS_REF = 1;
	localparam int POS_TEMP = 0;
	localparam int POS_READY = 7;
	localparam int POS_CNT = 6;
	localparam int POS_CHK = 4;
	localparam int POS_BURN = 3;
	localparam int POS_EXC = 0;
	localparam int POS_PIN_DIR = 2;
	localparam int POS_PIN_SRC = 1;
	localparam int POS_PIN_DAT = 0;
	localparam logic [7:0] STAT_WR_MASK = 8'h7F;
	// codes
	localparam logic [2:0] RATE_RESERVED = 3'h7;
	localparam logic [1:0] CHK_RESERVED = 2'h3;
	// modulator clock rates and period counts at 50 mhz
	localparam int CLK_HZ = 50000000;
	localparam int MOD_NORMAL_HZ = 256000;
	localparam int MOD_FAST_HZ = 512000;
	localparam int DIV_NORMAL = CLK_HZ / MOD_NORMAL_HZ;
	localparam int DIV_FAST = CLK_HZ / MOD_FAST_HZ;
	// modulator ticks per conversion, normal mode, per rate code
	localparam int TICKS_20 = MOD_NORMAL_HZ / 20;
	localparam int TICKS_45 = MOD_NORMAL_HZ / 45;
	localparam int TICKS_90 = MOD_NORMAL_HZ / 90;
	localparam int TICKS_175 = MOD_NORMAL_HZ / 175;
	localparam int TICKS_330 = MOD_NORMAL_HZ / 330;
	localparam int TICKS_600 = MOD_NORMAL_HZ / 600;
	localparam int TICKS_1000 = MOD_NORMAL_HZ / 1000;

	typedef enum logic [1:0] {
		ACFG_IDLE = 2'b00,
		ACFG_CONV = 2'b01
	} acfg_conv_t;

	typedef struct packed {
		logic [2:0] data_rate_sel;
		logic fast_mode;
		logic conversion_continuous_sel;
		logic [1:0] ref_sel;
		logic temp_sensor_enable;
	} acfg_rate_t;

	typedef struct packed {
		logic result_ready_flag;
		logic conversion_counter_enable;
		logic [1:0] integrity_sel;
		logic burnout_source_enable;
		logic [2:0] excitation_current_level;
	} acfg_stat_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} acfg_apb_req_t;
endpackage

// file: hdl/acfg_sync3.sv
// three-stage synchroniser for one pin level
// assumes a single core_clk domain
`timescale 1ns/1ps
module acfg_sync3 (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic pin,
	output logic level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} acfg_sync_t;
	acfg_sync_t st;
	acfg_sync_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// change counts only once stages two and three agree
		if (st.s2 == st.s3) begin
			next_st.level = st.s3;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;
endmodule

// file: hdl/acfg_regs.sv
// two adc configuration registers, apb slave, conversion timing model
// assumes apb master on core_clk; pin_two_in is asynchronous
`timescale 1ns/1ps
module acfg_regs (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pin_two_in,
	output logic pin_two_out,
	output logic pin_two_oe_n,
	output logic [2:0] data_rate_sel,
	output logic fast_mode,
	output logic conversion_continuous_sel,
	output logic [1:0] ref_sel,
	output logic temp_sensor_enable,
	output logic input_mux_bypass,
	output logic conversion_counter_enable,
	output logic [1:0] integrity_sel,
	output logic burnout_source_enable,
	output logic [2:0] excitation_current_level,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		acfg_pkg::acfg_rate_t rate;
		acfg_pkg::acfg_stat_t stat;
		logic pin_dir;
		logic pin_two_source_sel;
		logic pin_dat;
		logic [1:0] evt;
		logic [1:0] evt_en;
		logic [15:0] result_count;
		acfg_pkg::acfg_conv_t conv;
		logic start_req;
		logic [7:0] mod_div;
		logic [15:0] tick_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic pin_out;
		logic pin_oe_n;
		logic irq;
		logic [1:0] ref_out;
	} acfg_state_t;

	acfg_state_t st;
	acfg_state_t next_st;
	logic pin_level;
	logic setup_wr;
	logic setup_rd;
	logic mod_tick;
	logic [15:0] conv_len;
	logic [7:0] div_len;
	logic mapped;

	acfg_sync3 u_pin_sync (
		.core_clk(core_clk),
		.rst(rst),
		.pin(pin_two_in),
		.level(pin_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// answers in the access cycle following setup
	assign setup_wr = psel && !penable && pwrite;
	assign setup_rd = psel && !penable && !pwrite;
	assign mapped = (paddr == acfg_pkg::OFF_RATE) || (paddr == acfg_pkg::OFF_STAT)
		|| (paddr == acfg_pkg::OFF_PIN) || (paddr == acfg_pkg::OFF_EVT)
		|| (paddr == acfg_pkg::OFF_EVT_EN) || (paddr == acfg_pkg::OFF_EVT_CLR)
		|| (paddr == acfg_pkg::OFF_RESULT);

	always_comb begin
		// modulator clock selection
		if (st.rate.fast_mode) begin
			div_len = 8'(acfg_pkg::DIV_FAST);
		end else begin
			div_len = 8'(acfg_pkg::DIV_NORMAL);
		end
		// ticks per conversion; fast mode doubles rate via faster ticks
		case (st.rate.data_rate_sel)
			3'h0: conv_len = 16'(acfg_pkg::TICKS_20);
			3'h1: conv_len = 16'(acfg_pkg::TICKS_45);
			3'h2: conv_len = 16'(acfg_pkg::TICKS_90);
			3'h3: conv_len = 16'(acfg_pkg::TICKS_175);
			3'h4: conv_len = 16'(acfg_pkg::TICKS_330);
			3'h5: conv_len = 16'(acfg_pkg::TICKS_600);
			3'h6: conv_len = 16'(acfg_pkg::TICKS_1000);
			default: conv_len = 16'(acfg_pkg::TICKS_1000);
		endcase
	end

	assign mod_tick = (st.mod_div == 8'h00);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		next_st.start_req = 1'b0;
		if (mod_tick) begin
			next_st.mod_div = div_len - 8'h01;
		end else begin
			next_st.mod_div = st.mod_div - 8'h01;
		end

		// bus side
		if (setup_wr) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !mapped;
			if (paddr == acfg_pkg::OFF_RATE) begin
				next_st.rate = acfg_pkg::acfg_rate_t'(pwdata[7:0]);
				next_st.start_req = 1'b1;
			end else if (paddr == acfg_pkg::OFF_STAT) begin
				// ready flag kept
				next_st.stat.conversion_counter_enable = pwdata[acfg_pkg::POS_CNT];
				next_st.stat.integrity_sel = pwdata[acfg_pkg::POS_CHK +: 2];
				next_st.stat.burnout_source_enable = pwdata[acfg_pkg::POS_BURN];
				next_st.stat.excitation_current_level = pwdata[acfg_pkg::POS_EXC +: 3];
			end else if (paddr == acfg_pkg::OFF_PIN) begin
				next_st.pin_dir = pwdata[acfg_pkg::POS_PIN_DIR];
				next_st.pin_two_source_sel = pwdata[acfg_pkg::POS_PIN_SRC];
				next_st.pin_dat = pwdata[acfg_pkg::POS_PIN_DAT];
			end else if (paddr == acfg_pkg::OFF_EVT_EN) begin
				next_st.evt_en = pwdata[1:0];
			end else if (paddr == acfg_pkg::OFF_EVT_CLR) begin
				next_st.evt = st.evt & ~pwdata[1:0];
			end
		end else if (setup_rd) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !mapped;
			next_st.prdata = 32'h0000_0000;
			if (paddr == acfg_pkg::OFF_RATE) begin
				next_st.prdata[7:0] = st.rate;
			end else if (paddr == acfg_pkg::OFF_STAT) begin
				next_st.prdata[7:0] = st.stat;
			end else if (paddr == acfg_pkg::OFF_PIN) begin
				next_st.prdata[3:0] = {pin_level, st.pin_dir, st.pin_two_source_sel,
					st.pin_dat};
			end else if (paddr == acfg_pkg::OFF_EVT) begin
				next_st.prdata[1:0] = st.evt;
			end else if (paddr == acfg_pkg::OFF_EVT_EN) begin
				next_st.prdata[1:0] = st.evt_en;
			end else if (paddr == acfg_pkg::OFF_RESULT) begin
				next_st.prdata[15:0] = st.result_count;
				// reading conversion data clears ready
				next_st.stat.result_ready_flag = 1'b0;
			end
		end

		// conversion sequencer: single-shot or continuous
		case (st.conv)
			acfg_pkg::ACFG_IDLE: begin
				if (st.start_req || st.rate.conversion_continuous_sel) begin
					next_st.conv = acfg_pkg::ACFG_CONV;
					next_st.tick_cnt = conv_len;
				end
			end
			acfg_pkg::ACFG_CONV: begin
				if (mod_tick) begin
					if (st.tick_cnt <= 16'h0001) begin
						// new result: set wins over read clear
						next_st.stat.result_ready_flag = 1'b1;
						next_st.evt[0] = 1'b1;
						if (st.stat.conversion_counter_enable) begin
							next_st.result_count = st.result_count + 16'h0001;
						end
						if (st.rate.conversion_continuous_sel) begin
							next_st.tick_cnt = conv_len;
						end else begin
							next_st.conv = acfg_pkg::ACFG_IDLE;
						end
					end else begin
						next_st.tick_cnt = st.tick_cnt - 16'h0001;
					end
				end
			end
			default: next_st.conv = acfg_pkg::ACFG_IDLE;
		endcase

		// reserved code programmed is flagged as an event
		if (st.rate.data_rate_sel == acfg_pkg::RATE_RESERVED
			|| st.stat.integrity_sel == acfg_pkg::CHK_RESERVED) begin
			next_st.evt[1] = 1'b1;
		end

		// reference seen by the converter, forced internal in temp mode
		if (next_st.rate.temp_sensor_enable) begin
			next_st.ref_out = 2'h0;
		end else begin
			next_st.ref_out = next_st.rate.ref_sel;
		end

		// pin two drive
		next_st.pin_oe_n = !st.pin_dir;
		next_st.pin_out = st.pin_two_source_sel ? st.stat.result_ready_flag : st.pin_dat;
		next_st.irq = |(next_st.evt & st.evt_en);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.rate <= acfg_pkg::RST_RATE;
			st.stat <= acfg_pkg::RST_STAT;
			st.pin_oe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign pin_two_out = st.pin_out;
	assign pin_two_oe_n = st.pin_oe_n;
	assign data_rate_sel = st.rate.data_rate_sel;
	assign fast_mode = st.rate.fast_mode;
	assign conversion_continuous_sel = st.rate.conversion_continuous_sel;
	// registered copy keeps the reference output glitch free
	assign ref_sel = st.ref_out;
	assign temp_sensor_enable = st.rate.temp_sensor_enable;
	assign input_mux_bypass = st.rate.temp_sensor_enable;
	assign conversion_counter_enable = st.stat.conversion_counter_enable;
	assign integrity_sel = st.stat.integrity_sel;
	assign burnout_source_enable = st.stat.burnout_source_enable;
	assign excitation_current_level = st.stat.excitation_current_level;
	assign irq = st.irq;

	////////////////////////////////////////////////////////////////////////////////
	a_apb_answer: assert property (@(posedge core_clk) disable iff (rst)
		(psel && !penable) |=> pready)
		else $error("no answer after setup");
	a_ready_write: assert property (@(posedge core_clk) disable iff (rst)
		(setup_wr && paddr == acfg_pkg::OFF_STAT && !st.stat.result_ready_flag
			&& !(st.conv == acfg_pkg::ACFG_CONV && mod_tick))
		|=> !st.stat.result_ready_flag)
		else $error("write changed ready flag");
	a_stat_store: assert property (@(posedge core_clk) disable iff (rst)
		(setup_wr && paddr == acfg_pkg::OFF_STAT)
		|=> st.stat[6:0] == $past(pwdata[6:0]))
		else $error("status fields not stored");
	a_ready_clear: assert property (@(posedge core_clk) disable iff (rst)
		(setup_rd && paddr == acfg_pkg::OFF_RESULT && !(st.conv == acfg_pkg::ACFG_CONV
			&& mod_tick && st.tick_cnt <= 16'h0001)) |=> !st.stat.result_ready_flag)
		else $error("ready not cleared by read");
	a_temp_ref: assert property (@(posedge core_clk) disable iff (rst)
		temp_sensor_enable |-> ref_sel == 2'h0 && input_mux_bypass)
		else $error("temp mode not on internal reference");
	a_pin_src: assert property (@(posedge core_clk) disable iff (rst)
		st.pin_two_source_sel && st.pin_dir |=> pin_two_out == $past(st.stat.result_ready_flag)
			&& !pin_two_oe_n)
		else $error("pin two not driven by ready");
	a_single_stop: assert property (@(posedge core_clk) disable iff (rst)
		(st.conv == acfg_pkg::ACFG_IDLE && !st.start_req && !conversion_continuous_sel)
		|=> st.conv == acfg_pkg::ACFG_IDLE)
		else $error("conversion started without request");
	a_rate_div: assert property (@(posedge core_clk) disable iff (rst)
		mod_tick |=> st.mod_div == $past(div_len) - 8'h01)
		else $error("modulator divider wrong");

	////////////////////////////////////////////////////////////////////////////////
	// conversion sequencer and counter checks
	sequence s_conv_done;
		st.conv == acfg_pkg::ACFG_CONV && mod_tick && st.tick_cnt <= 16'h0001;
	endsequence

	sequence s_rate_write;
		setup_wr && paddr == acfg_pkg::OFF_RATE;
	endsequence

	a_done_ready: assert property (@(posedge core_clk) disable iff (rst)
		s_conv_done |=> st.stat.result_ready_flag && st.evt[0])
		else $error("result ready not set on completion");
	a_done_count: assert property (@(posedge core_clk) disable iff (rst)
		s_conv_done ##0 st.stat.conversion_counter_enable
		|=> st.result_count == $past(st.result_count) + 16'h0001)
		else $error("result counter not advanced");
	a_count_hold: assert property (@(posedge core_clk) disable iff (rst)
		!st.stat.conversion_counter_enable |=> $stable(st.result_count))
		else $error("disabled counter moved");
	a_cont_restart: assert property (@(posedge core_clk) disable iff (rst)
		s_conv_done ##0 st.rate.conversion_continuous_sel
		|=> st.conv == acfg_pkg::ACFG_CONV && st.tick_cnt == $past(conv_len))
		else $error("continuous conversion not restarted");
	a_single_end: assert property (@(posedge core_clk) disable iff (rst)
		s_conv_done ##0 !st.rate.conversion_continuous_sel
		|=> st.conv == acfg_pkg::ACFG_IDLE)
		else $error("single conversion did not stop");
	a_rate_start: assert property (@(posedge core_clk) disable iff (rst)
		s_rate_write |=> st.start_req)
		else $error("rate write did not request a conversion");
	a_start_conv: assert property (@(posedge core_clk) disable iff (rst)
		(st.conv == acfg_pkg::ACFG_IDLE && (st.start_req || st.rate.conversion_continuous_sel))
		|=> st.conv == acfg_pkg::ACFG_CONV && st.tick_cnt == $past(conv_len))
		else $error("conversion not started with rate length");
	a_tick_count: assert property (@(posedge core_clk) disable iff (rst)
		(st.conv == acfg_pkg::ACFG_CONV && mod_tick && st.tick_cnt > 16'h0001)
		|=> st.tick_cnt == $past(st.tick_cnt) - 16'h0001)
		else $error("tick counter not decremented");
	a_tick_hold: assert property (@(posedge core_clk) disable iff (rst)
		(st.conv == acfg_pkg::ACFG_CONV && !mod_tick) |=> $stable(st.tick_cnt))
		else $error("tick counter moved between ticks");
	a_div_fast: assert property (@(posedge core_clk) disable iff (rst)
		(mod_tick && st.rate.fast_mode) |=> st.mod_div == 8'(acfg_pkg::DIV_FAST - 1))
		else $error("fast modulator period wrong");
	a_div_normal: assert property (@(posedge core_clk) disable iff (rst)
		(mod_tick && !st.rate.fast_mode) |=> st.mod_div == 8'(acfg_pkg::DIV_NORMAL - 1))
		else $error("normal modulator period wrong");
	a_reserved_evt: assert property (@(posedge core_clk) disable iff (rst)
		(st.rate.data_rate_sel == acfg_pkg::RATE_RESERVED
			|| st.stat.integrity_sel == acfg_pkg::CHK_RESERVED) |=> st.evt[1])
		else $error("reserved code not flagged");

	////////////////////////////////////////////////////////////////////////////////
	// register and pin checks
	a_ready_hold: assert property (@(posedge core_clk) disable iff (rst)
		!(st.conv == acfg_pkg::ACFG_CONV && mod_tick && st.tick_cnt <= 16'h0001)
			&& !(setup_rd && paddr == acfg_pkg::OFF_RESULT)
		|=> $stable(st.stat.result_ready_flag))
		else $error("ready flag moved without cause");
	a_stat_read: assert property (@(posedge core_clk) disable iff (rst)
		(setup_rd && paddr == acfg_pkg::OFF_STAT) |=> pready && prdata[7:0] == $past(st.stat))
		else $error("status read data wrong");
	a_ref_follow: assert property (@(posedge core_clk) disable iff (rst)
		!st.rate.temp_sensor_enable |-> ref_sel == st.rate.ref_sel)
		else $error("reference output not stored value");
	a_pin_dat: assert property (@(posedge core_clk) disable iff (rst)
		(st.pin_dir && !st.pin_two_source_sel) |=> pin_two_out == $past(st.pin_dat))
		else $error("pin two not driven by level bit");
	a_pin_input: assert property (@(posedge core_clk) disable iff (rst)
		!st.pin_dir |=> pin_two_oe_n)
		else $error("pin two driven while input");
endmodule

// file: verif/acfg_host.sv
// apb host model that issues register reads and writes
// assumes the bench calls xfer from the core_clk domain
`timescale 1ns/1ps
module acfg_host (
	input wire logic core_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	////////////////////////////////////////////////////////////////
	// one transfer; callers keep reserved codes out of normal traffic
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released bus shows no stale value
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// file: verif/testbench.sv
// self-checking bench for the adc configuration registers
// assumes acfg_regs and the apb host model acfg_host
`timescale 1ns/1ps
module testbench;
	logic core_clk;
	logic rst;
	logic ext_pin;
	logic psel, penable, pwrite, pready, pslverr, pin_two_out, pin_two_oe_n;
	logic fast_mode, cont_sel, temp_en, mux_bypass, cnt_en, burn_en, irq, errv;
	logic [7:0] paddr, v;
	logic [31:0] pwdata, prdata, rdv;
	logic [2:0] rate, exc;
	logic [1:0] ref_sel, chk;
	wire pin_two_in;
	int err_count, comparisons, cycles;

	// wire level: the pad when driven, else the outside source
	assign pin_two_in = pin_two_oe_n ? ext_pin : pin_two_out;

	acfg_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	acfg_regs uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_two_in(pin_two_in), .pin_two_out(pin_two_out),
		.pin_two_oe_n(pin_two_oe_n), .data_rate_sel(rate), .fast_mode(fast_mode),
		.conversion_continuous_sel(cont_sel), .ref_sel(ref_sel),
		.temp_sensor_enable(temp_en), .input_mux_bypass(mux_bypass),
		.conversion_counter_enable(cnt_en), .integrity_sel(chk),
		.burnout_source_enable(burn_en), .excitation_current_level(exc), .irq(irq));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rdv, errv);
		@(posedge core_clk);
		#1;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 32'h0, rdv, errv);
		check(nm, exp, rdv);
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		ext_pin = 1'b0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk("rate reset", acfg_pkg::OFF_RATE, 32'h0);
		rd_chk("stat reset", acfg_pkg::OFF_STAT, 32'h0);
		check("oe_n reset", 32'h1, 32'(pin_two_oe_n));
		for (int i = 0; i < 7; i++) begin
			v = {i[2:0], i[0], i == 3, i[1:0], 1'b0};
			wr(acfg_pkg::OFF_RATE, 32'(v));
			rd_chk("rate rb", acfg_pkg::OFF_RATE, 32'(v));
			check("rate", 32'(v[7:5]), 32'(rate));
			check("fast", 32'(v[4]), 32'(fast_mode));
			check("cont", 32'(v[3]), 32'(cont_sel));
			check("ref", 32'(v[2:1]), 32'(ref_sel));
		end
		wr(acfg_pkg::OFF_RATE, 32'h23);
		check("ref temp", 32'h0, 32'(ref_sel));
		check("bypass", 32'h1, 32'(mux_bypass));
		for (int i = 0; i < 8; i++) begin
			v = {1'b0, i[0], 2'(i % 3), i[1], i[2:0]};
			wr(acfg_pkg::OFF_STAT, 32'(v));
			rd_chk("stat rb", acfg_pkg::OFF_STAT, 32'(v));
			check("cnt", 32'(v[6]), 32'(cnt_en));
			check("chk", 32'(v[5:4]), 32'(chk));
			check("burn", 32'(v[3]), 32'(burn_en));
			check("exc", 32'(v[2:0]), 32'(exc));
		end
		host.xfer(1'b0, 8'h3C, 32'h0, rdv, errv);
		check("unmapped err", 32'h1, 32'(errv));
		check("unmapped data", 32'h0, rdv);
		// mid-run reset also stops the conversion left running above
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		rd_chk("stat rst2", acfg_pkg::OFF_STAT, 32'h0);
		rd_chk("rate rst2", acfg_pkg::OFF_RATE, 32'h0);
		check("oe_n rst2", 32'h1, 32'(pin_two_oe_n));
		ext_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd_chk("pin in", acfg_pkg::OFF_PIN, 32'h8);
		wr(acfg_pkg::OFF_STAT, 32'h40);
		wr(acfg_pkg::OFF_EVT_CLR, 32'h3);
		wr(acfg_pkg::OFF_EVT_EN, 32'h1);
		wr(acfg_pkg::OFF_PIN, 32'h6);
		check("oe_n out", 32'h0, 32'(pin_two_oe_n));
		check("pin idle", 32'h0, 32'(pin_two_out));
		wr(acfg_pkg::OFF_RATE, 32'hD0);
		for (int k = 0; k < 30000 && irq !== 1'b1; k++) @(posedge core_clk);
		#1;
		check("irq done", 32'h1, 32'(irq));
		rd_chk("evt", acfg_pkg::OFF_EVT, 32'h1);
		rd_chk("ready", acfg_pkg::OFF_STAT, 32'hC0);
		check("pin ready", 32'h1, 32'(pin_two_out));
		wr(acfg_pkg::OFF_STAT, 32'h5F);
		rd_chk("ready kept", acfg_pkg::OFF_STAT, 32'hDF);
		wr(acfg_pkg::OFF_EVT_EN, 32'h0);
		check("irq masked", 32'h0, 32'(irq));
		wr(acfg_pkg::OFF_EVT_EN, 32'h1);
		check("irq unmasked", 32'h1, 32'(irq));
		wr(acfg_pkg::OFF_EVT_CLR, 32'h1);
		check("irq cleared", 32'h0, 32'(irq));
		rd_chk("clr reads 0", acfg_pkg::OFF_EVT_CLR, 32'h0);
		host.xfer(1'b0, acfg_pkg::OFF_RESULT, 32'h0, rdv, errv);
		check("result count", 32'h1, rdv);
		rd_chk("ready clr", acfg_pkg::OFF_STAT, 32'h5F);
		check("pin clr", 32'h0, 32'(pin_two_out));
		test_done();
	end
endmodule
